// file: flash_seq_pkg.sv
// package of register map, op codes and timing for the flash sequencer
package flash_seq_pkg;
   // register word offsets (byte addresses)
   localparam logic [5:0] OFS_CONTROL     = 6'h00;
   localparam logic [5:0] OFS_TARGET_LO   = 6'h04;
   localparam logic [5:0] OFS_TARGET_HI   = 6'h08;
   localparam logic [5:0] OFS_KEY         = 6'h0C;
   localparam logic [5:0] OFS_SRC_LO      = 6'h10;
   localparam logic [5:0] OFS_SRC_HI      = 6'h14;
   localparam logic [5:0] OFS_FI_CFG_LO   = 6'h18;
   localparam logic [5:0] OFS_FI_CFG_HI   = 6'h1C;
   localparam logic [5:0] OFS_FI_MATCH_LO = 6'h20;
   localparam logic [5:0] OFS_FI_MATCH_HI = 6'h24;

   // control register fields
   localparam int CTL_START_BIT  = 15;
   localparam int CTL_PERMIT_BIT = 14;
   localparam int CTL_ERR_BIT    = 13;

   // unlock key values
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // operation select codes
   localparam logic [3:0] OP_BULK_ERASE  = 4'hE;
   localparam logic [3:0] OP_BOOT_DWORD  = 4'h8;
   localparam logic [3:0] OP_PART_ERASE  = 4'h4;
   localparam logic [3:0] OP_PAGE_ERASE  = 4'h3;
   localparam logic [3:0] OP_ROW_PROGRAM = 4'h2;
   localparam logic [3:0] OP_DWORD       = 4'h1;

   // double word alignment: 4-word boundary, 2 address units per word
   localparam logic [23:0] DWORD_ALIGN_MASK = 24'hFFFFF8;

   // ecc word width and lowest out-of-range pointer
   localparam int         ECC_WIDTH   = 56;
   localparam logic [7:0] PTR_LIMIT   = 8'h38;

   // operation duration defaults in microseconds
   localparam int OP_TIME_US  = 20;
   localparam int CLK_MHZ     = 100;
   localparam int OP_CYCLES   = OP_TIME_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUSY = 3'b010,
      ST_DONE = 3'b100
   } seq_state_t;

   // flash macro command carrier
   typedef struct packed {
      logic        valid;
      logic [3:0]  op;
      logic [23:0] addr;
      logic [23:0] src;
   } flash_cmd_t;

   // ecc read path carrier
   typedef struct packed {
      logic                 valid;
      logic [23:0]          addr;
      logic [ECC_WIDTH-1:0] word;
   } ecc_word_t;
endpackage : flash_seq_pkg

// file: flash_program_erase_ecc_inject.sv
// flash program/erase sequencer with ecc fault injection, wishbone slave
`timescale 1ns/1ps
module flash_program_erase_ecc_inject #(
   parameter int OP_CYCLES = flash_seq_pkg::OP_CYCLES
) (
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   input  wire logic                      por_n,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [5:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   output flash_seq_pkg::flash_cmd_t      flashCmd,
   input  wire logic                      flashDone,
   input  wire logic                      powerSaveReq,
   output logic                           powerSaveGo,
   input  wire flash_seq_pkg::ecc_word_t  eccIn,
   output flash_seq_pkg::ecc_word_t       eccOut
);
   localparam int CW = $clog2(OP_CYCLES + 1);

   flash_seq_pkg::seq_state_t stateFf;
   logic [3:0]  opSelFf;
   logic        permitFf;
   logic        errFf;
   logic [15:0] targetLoFf;
   logic [7:0]  targetHiFf;
   logic [15:0] srcLoFf;
   logic [7:0]  srcHiFf;
   logic        fiEnFf;
   logic [7:0]  ptrAFf;
   logic [7:0]  ptrBFf;
   logic [15:0] matchLoFf;
   logic [7:0]  matchHiFf;
   logic [1:0]  keyStageFf;
   logic [CW-1:0] cntFf;
   logic        ackFf;
   logic [31:0] rdDataFf;

   logic        busReq;
   logic        wrStb;
   logic        rdStb;
   logic [15:0] wData;
   logic        startReq;
   logic        opLegal;
   logic        busy;
   logic [23:0] targetAddr;
   logic [23:0] srcAddr;

   assign busReq   = wb_cyc_i & wb_stb_i & ~ackFf;
   assign wrStb    = busReq & wb_we_i;
   assign rdStb    = busReq & ~wb_we_i;
   assign wData    = wb_dat_i[15:0];
   assign wb_ack_o = ackFf;
   assign wb_dat_o = rdDataFf;
   assign busy     = (stateFf != flash_seq_pkg::ST_IDLE);
   assign startReq = wrStb && wb_adr_i == flash_seq_pkg::OFS_CONTROL && wb_sel_i[1]
                     && wData[flash_seq_pkg::CTL_START_BIT] && !busy;
   assign targetAddr = {targetHiFf, targetLoFf};
   assign srcAddr    = {srcHiFf, srcLoFf};

   always_comb begin
      unique case (opSelFf)
         flash_seq_pkg::OP_BULK_ERASE,
         flash_seq_pkg::OP_BOOT_DWORD,
         flash_seq_pkg::OP_PART_ERASE,
         flash_seq_pkg::OP_PAGE_ERASE,
         flash_seq_pkg::OP_ROW_PROGRAM,
         flash_seq_pkg::OP_DWORD: opLegal = 1'b1;
         default: opLegal = 1'b0;
      endcase
   end

   // single cycle ack, one idle cycle between accesses
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ackFf <= 1'b0;
      end else begin
         ackFf <= busReq;
      end
   end

   // op select survives all resets except power-on
   always_ff @(posedge sys_clk) begin
      if (!por_n) begin
         opSelFf <= 4'h0;
      end else if (wrStb && wb_adr_i == flash_seq_pkg::OFS_CONTROL && wb_sel_i[0] && !busy) begin
         opSelFf <= wData[3:0];
      end
   end

   // write permit and sequence error, power-on reset only
   always_ff @(posedge sys_clk) begin
      if (!por_n) begin
         permitFf <= 1'b0;
         errFf    <= 1'b0;
      end else begin
         if (wrStb && wb_adr_i == flash_seq_pkg::OFS_CONTROL && wb_sel_i[1]) begin
            permitFf <= wData[flash_seq_pkg::CTL_PERMIT_BIT];
            if (!wData[flash_seq_pkg::CTL_ERR_BIT]) begin
               errFf <= 1'b0;
            end
         end
         if (startReq && (keyStageFf != 2'd2 || !permitFf)) begin
            errFf <= 1'b1;
         end
      end
   end

   // unlock key tracker: 0x55 then 0xAA as consecutive bus writes
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         keyStageFf <= 2'd0;
      end else if (wrStb) begin
         if (wb_adr_i == flash_seq_pkg::OFS_KEY && wb_sel_i[0]
             && wData[7:0] == flash_seq_pkg::KEY_FIRST) begin
            keyStageFf <= 2'd1;
         end else if (wb_adr_i == flash_seq_pkg::OFS_KEY && wb_sel_i[0] && keyStageFf == 2'd1
                      && wData[7:0] == flash_seq_pkg::KEY_SECOND) begin
            keyStageFf <= 2'd2;
         end else begin
            keyStageFf <= 2'd0;
         end
      end
   end

   // address and configuration registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         targetLoFf <= 16'h0000;
         targetHiFf <= 8'h00;
         srcLoFf    <= 16'h0000;
         srcHiFf    <= 8'h00;
         fiEnFf     <= 1'b0;
         ptrAFf     <= 8'h00;
         ptrBFf     <= 8'h00;
         matchLoFf  <= 16'h0000;
         matchHiFf  <= 8'h00;
      end else if (wrStb) begin
         unique case (wb_adr_i)
            flash_seq_pkg::OFS_TARGET_LO: begin
               if (wb_sel_i[0]) targetLoFf[7:0]  <= wData[7:0];
               if (wb_sel_i[1]) targetLoFf[15:8] <= wData[15:8];
            end
            flash_seq_pkg::OFS_TARGET_HI: begin
               if (wb_sel_i[0]) targetHiFf <= wData[7:0];
            end
            flash_seq_pkg::OFS_SRC_LO: begin
               if (wb_sel_i[0]) srcLoFf[7:0]  <= wData[7:0];
               if (wb_sel_i[1]) srcLoFf[15:8] <= wData[15:8];
            end
            flash_seq_pkg::OFS_SRC_HI: begin
               if (wb_sel_i[0]) srcHiFf <= wData[7:0];
            end
            flash_seq_pkg::OFS_FI_CFG_LO: begin
               if (wb_sel_i[0]) fiEnFf <= wData[0];
            end
            flash_seq_pkg::OFS_FI_CFG_HI: begin
               if (wb_sel_i[0]) ptrAFf <= wData[7:0];
               if (wb_sel_i[1]) ptrBFf <= wData[15:8];
            end
            flash_seq_pkg::OFS_FI_MATCH_LO: begin
               if (wb_sel_i[0]) matchLoFf[7:0]  <= wData[7:0];
               if (wb_sel_i[1]) matchLoFf[15:8] <= wData[15:8];
            end
            flash_seq_pkg::OFS_FI_MATCH_HI: begin
               if (wb_sel_i[0]) matchHiFf <= wData[7:0];
            end
            default: ;
         endcase
      end
   end

   // sequencer: counts OP_CYCLES, then waits for flashDone unless the op is illegal
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stateFf  <= flash_seq_pkg::ST_IDLE;
         cntFf    <= '0;
         flashCmd <= '0;
      end else begin
         flashCmd.valid <= 1'b0;
         unique case (stateFf)
            flash_seq_pkg::ST_IDLE: begin
               if (startReq && keyStageFf == 2'd2 && permitFf) begin
                  stateFf <= flash_seq_pkg::ST_BUSY;
                  cntFf   <= CW'(OP_CYCLES);
                  flashCmd.valid <= opLegal;
                  flashCmd.op    <= opSelFf;
                  flashCmd.src   <= srcAddr;
                  if (opSelFf == flash_seq_pkg::OP_DWORD
                      || opSelFf == flash_seq_pkg::OP_BOOT_DWORD) begin
                     flashCmd.addr <= targetAddr & flash_seq_pkg::DWORD_ALIGN_MASK;
                  end else begin
                     flashCmd.addr <= targetAddr;
                  end
               end
            end
            flash_seq_pkg::ST_BUSY: begin
               if (cntFf != '0) begin
                  cntFf <= cntFf - CW'(1);
               end
               if (cntFf == '0 && (flashDone || !opLegal)) begin
                  stateFf <= flash_seq_pkg::ST_DONE;
               end
            end
            flash_seq_pkg::ST_DONE: begin
               stateFf <= flash_seq_pkg::ST_IDLE;
            end
            default: stateFf <= flash_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // power-save request passes only while idle
   assign powerSaveGo = powerSaveReq & ~busy;

   // read mux
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdDataFf <= 32'h0000_0000;
      end else if (rdStb) begin
         unique case (wb_adr_i)
            flash_seq_pkg::OFS_CONTROL:
               rdDataFf <= {16'h0000, busy, permitFf, errFf, 9'h000, opSelFf};
            flash_seq_pkg::OFS_TARGET_LO:   rdDataFf <= {16'h0000, targetLoFf};
            flash_seq_pkg::OFS_TARGET_HI:   rdDataFf <= {24'h000000, targetHiFf};
            flash_seq_pkg::OFS_KEY:         rdDataFf <= 32'h0000_0000;
            flash_seq_pkg::OFS_SRC_LO:      rdDataFf <= {16'h0000, srcLoFf};
            flash_seq_pkg::OFS_SRC_HI:      rdDataFf <= {24'h000000, srcHiFf};
            flash_seq_pkg::OFS_FI_CFG_LO:   rdDataFf <= {31'h0000_0000, fiEnFf};
            flash_seq_pkg::OFS_FI_CFG_HI:   rdDataFf <= {16'h0000, ptrBFf, ptrAFf};
            flash_seq_pkg::OFS_FI_MATCH_LO: rdDataFf <= {16'h0000, matchLoFf};
            flash_seq_pkg::OFS_FI_MATCH_HI: rdDataFf <= {24'h000000, matchHiFf};
            default:                        rdDataFf <= 32'h0000_0000;
         endcase
      end
   end

   // ecc fault injection on read path
   logic [flash_seq_pkg::ECC_WIDTH-1:0] flipMask;
   logic                                addrHit;
   assign addrHit = fiEnFf && eccIn.valid && eccIn.addr == {matchHiFf, matchLoFf};

   for (genvar i = 0; i < flash_seq_pkg::ECC_WIDTH; i++) begin : g_flip
      assign flipMask[i] = (ptrAFf < flash_seq_pkg::PTR_LIMIT && ptrAFf == 8'(i))
                         ^ (ptrBFf < flash_seq_pkg::PTR_LIMIT && ptrBFf == 8'(i));
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         eccOut <= '0;
      end else begin
         eccOut.valid <= eccIn.valid;
         eccOut.addr  <= eccIn.addr;
         eccOut.word  <= addrHit ? (eccIn.word ^ flipMask) : eccIn.word;
      end
   end
endmodule : flash_program_erase_ecc_inject

// file: flash_seq_asserts.sv
// port assertions for the flash sequencer
`timescale 1ns/1ps
module flash_seq_asserts #(
   parameter int OP_CYCLES = flash_seq_pkg::OP_CYCLES
) (
   input wire logic                       sys_clk,
   input wire logic                       rst_n,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [5:0]                 wb_adr_i,
   input wire logic [31:0]                wb_dat_o,
   input wire logic                       wb_ack_o,
   input wire flash_seq_pkg::flash_cmd_t  flashCmd,
   input wire logic                       powerSaveReq,
   input wire logic                       powerSaveGo,
   input wire flash_seq_pkg::ecc_word_t   eccIn,
   input wire flash_seq_pkg::ecc_word_t   eccOut
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd(logic [5:0] a);
      s_req ##0 (!wb_we_i && wb_adr_i == a);
   endsequence
   sequence s_go;
      flashCmd.valid;
   endsequence
   property p_ack;
      s_req |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_keyRd;
      s_rd(6'h0C) ##1 wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_keyRd: assert property (p_keyRd) else $error("key read not zero");
   property p_hiRd;
      s_rd(6'h08) ##1 wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   a_hiRd: assert property (p_hiRd) else $error("target high top bits set");
   property p_opLegal;
      s_go |-> flashCmd.op inside {4'hE, 4'h8, 4'h4, 4'h3, 4'h2, 4'h1};
   endproperty
   a_opLegal: assert property (p_opLegal) else $error("reserved op issued");
   property p_align;
      s_go ##0 flashCmd.op == 4'h1 |-> flashCmd.addr[2:0] == 3'h0;
   endproperty
   a_align: assert property (p_align) else $error("double word unaligned");
   property p_single;
      s_go |=> !flashCmd.valid [*8];
   endproperty
   a_single: assert property (p_single) else $error("restart while busy");
   property p_psBusy;
      s_go |=> !powerSaveGo [*8];
   endproperty
   a_psBusy: assert property (p_psBusy) else $error("power save while busy");
   property p_psGate;
      powerSaveGo |-> powerSaveReq;
   endproperty
   a_psGate: assert property (p_psGate) else $error("power save unrequested");
   property p_eccLat;
      eccOut.valid == $past(eccIn.valid) && eccOut.addr == $past(eccIn.addr);
   endproperty
   a_eccLat: assert property (p_eccLat) else $error("ecc path latency");
   property p_eccFlip;
      $countones(eccOut.word ^ $past(eccIn.word)) <= 2;
   endproperty
   a_eccFlip: assert property (p_eccFlip) else $error("too many ecc flips");
endmodule : flash_seq_asserts

bind flash_program_erase_ecc_inject flash_seq_asserts #(.OP_CYCLES(OP_CYCLES)) chk_u (
   .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .flashCmd(flashCmd), .powerSaveReq(powerSaveReq), .powerSaveGo(powerSaveGo),
   .eccIn(eccIn), .eccOut(eccOut));

// file: tb_top.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   logic                      sys_clk, rst_n, por_n, cyc, stb, we, ack, done, psReq, psGo;
   logic [5:0]                adr;
   logic [3:0]                sel;
   logic [23:0]               mAddr;
   logic [31:0]               wdat, rdat, q, seed, v;
   flash_seq_pkg::flash_cmd_t cmd, cmdSeen;
   flash_seq_pkg::ecc_word_t  eIn, eOut;
   int                        bad_count, n_compared, nCmd;
   logic [5:0]  regOfs [10] = '{6'h04, 6'h08, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24,
                                6'h0C, 6'h28};
   logic [31:0] regMsk [10] = '{32'hFFFF, 32'hFF, 32'hFFFF, 32'hFF, 32'h1, 32'hFFFF,
                                32'hFFFF, 32'hFF, 32'h0, 32'h0};
   logic [3:0]  ops [9] = '{4'hE, 4'h8, 4'h4, 4'h3, 4'h2, 4'h1, 4'hF, 4'h0, 4'h5};
   flash_program_erase_ecc_inject #(.OP_CYCLES(10)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .flashCmd(cmd), .flashDone(done), .powerSaveReq(psReq),
      .powerSaveGo(psGo), .eccIn(eIn), .eccOut(eOut));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // capture the one-cycle command pulse
   always @(posedge sys_clk) if (cmd.valid === 1'b1) begin
      cmdSeen <= cmd;
      nCmd <= nCmd + 1;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [55:0] flip(input logic [55:0] w, input logic [7:0] a, b,
                                        input logic on);
      logic [55:0] m;
      m = '0;
      if (on && a < 8'h38) m[a] = 1'b1;
      if (on && b < 8'h38) m[b] = ~m[b];
      return w ^ m;
   endfunction : flip
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge sys_clk);
   endtask : wb
   task automatic rst(input logic pwr);
      rst_n <= 1'b0;
      por_n <= !pwr;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      @(posedge sys_clk);
   endtask : rst
   task automatic ecc(input logic en, input logic [7:0] a, b, input logic hit);
      logic [55:0] w;
      v = xs();
      w = {v[23:0], xs()};
      wb(1'b1, 6'h18, {31'h0, en});
      wb(1'b1, 6'h1C, {16'h0, b, a});
      eIn <= {1'b1, hit ? mAddr : mAddr ^ 24'h000001, w};
      @(posedge sys_clk);
      eIn <= '0;
      @(posedge sys_clk);
      `CHK("ecc word", flip(w, a, b, en && hit), eOut.word)
   endtask : ecc
   task automatic start(input logic [3:0] op, input logic key, input logic run);
      int k;
      k = nCmd;
      done <= 1'b0;
      if (key) wb(1'b1, 6'h0C, 32'h55);
      if (key) wb(1'b1, 6'h0C, 32'hAA);
      wb(1'b1, 6'h00, {16'h0, 4'hC, 8'h0, op});
      psReq <= 1'b1;
      repeat (12) @(posedge sys_clk);
      if (run) `CHK("power save held", 1'b0, psGo)
      done <= 1'b1;
      q = 32'h8000;
      for (int t = 0; t < 20 && q[15] !== 1'b0; t++) wb(1'b0, 6'h00, 32'h0);
      `CHK("busy cleared", 1'b0, q[15])
      `CHK("power save idle", 1'b1, psGo)
      `CHK("cmd count", k + run, nCmd)
      psReq <= 1'b0;
   endtask : start
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   initial begin
      #200us;
      bad_count++;
      test_done();
   end
   initial begin
      {rst_n, por_n, cyc, stb, we, done, psReq} = '0;
      adr = 6'h00;
      sel = 4'hF;
      wdat = 32'h0;
      eIn = '0;
      seed = 32'h63;
      rst(1'b1);
      foreach (regOfs[i]) begin
         if (i > 1) wb(1'b0, regOfs[i], 32'h0);
         if (i > 1) `CHK("reset value", 32'h0, q)
         v = xs();
         wb(1'b1, regOfs[i], v);
         wb(1'b0, regOfs[i], 32'h0);
         `CHK("reg rw", v & regMsk[i], q)
      end
      $display("test registers ended");
      mAddr = xs();
      wb(1'b1, 6'h20, {16'h0, mAddr[15:0]});
      wb(1'b1, 6'h24, {24'h0, mAddr[23:16]});
      ecc(1'b1, 8'h05, 8'h37, 1'b1);
      ecc(1'b1, 8'h38, 8'hFF, 1'b1);
      ecc(1'b1, 8'h09, 8'h09, 1'b1);
      ecc(1'b0, 8'h01, 8'h02, 1'b1);
      ecc(1'b1, 8'h00, 8'h20, 1'b0);
      repeat (6) ecc(1'b1, 8'(xs() % 64), {2'b0, seed[13:8]}, 1'b1);
      $display("test injection ended");
      foreach (ops[i]) begin
         v = xs();
         wb(1'b1, 6'h04, {16'h0, v[15:0]});
         wb(1'b1, 6'h08, {24'h0, v[23:16]});
         wb(1'b1, 6'h10, {16'h0, v[31:16]});
         wb(1'b1, 6'h14, {24'h0, v[7:0]});
         wb(1'b1, 6'h00, {16'h0, 4'h4, 8'h0, ops[i]});
         start(ops[i], 1'b1, i < 6);
         if (i < 6) `CHK("cmd op", ops[i], cmdSeen.op)
         if (i > 2 && i < 6) `CHK("cmd addr", v[23:0] & (i == 5 ? 24'hFFFFF8 : 24'hFFFFFF),
                                  cmdSeen.addr)
         if (i == 4) `CHK("cmd src", {v[7:0], v[31:16]}, cmdSeen.src)
      end
      start(4'h3, 1'b0, 1'b0);
      wb(1'b0, 6'h00, 32'h0);
      `CHK("sequence error", 1'b1, q[13])
      wb(1'b1, 6'h00, 32'h3);
      $display("test operations ended");
      rst(1'b0);
      wb(1'b0, 6'h00, 32'h0);
      `CHK("op kept", 4'h3, q[3:0])
      rst(1'b1);
      wb(1'b0, 6'h00, 32'h0);
      `CHK("op cleared", 4'h0, q[3:0])
      $display("test resets ended");
      test_done();
   end
endmodule : tb_top
